// [rtl/uart_rx_line_status.sv]
// receive line status, receive fifo and spare byte behind an apb slave
//
// What this block does
// - set stop-bit fault, clear it on status read
// - status read alone clears the stop-bit fault
// - fifo errors shown when character reaches head
// - break pushes exactly one zero character
// - after fault, two high samples, then start
// - parity mismatch sets parity fault, read clears
// - non-fifo overwrite of unread character flags overrun
// - status read clears the overrun fault
// - fifo overrun only when full plus new character
// - fifo overrun discards shift character, flags at once
// - receive available set once character is stored
// - receive available clears when all characters read
// - eight-bit spare byte, reset zero, no side effects
// - spare byte upper bits read zero
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module uart_rx_line_status (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire rx_status_pkg::apb_req_t apb_req,
  output rx_status_pkg::apb_rsp_t apb_rsp,
  // serial line
  input wire logic rxd,
  // interrupt
  output logic irq
);
  import rx_status_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    rx_char_t [FIFO_DEPTH-1:0] mem;
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] tail;
    logic [CNT_W-1:0] count;
    logic shown;
    logic fe;
    logic pe;
    logic oe;
    logic fifo_en;
    logic par_en;
    logic par_even;
    logic [1:0] trig_sel;
    logic [15:0] divisor;
    logic [7:0] spare;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic irq;
    apb_rsp_t rsp;
  } stat_t;

  stat_t s_reg, s_next;
  logic char_valid;
  rx_char_t rx_char;
  rx_char_t head_ch;
  logic setup, done, wr, rd, hit;
  logic pop, full, push, ovr;
  logic [CNT_W-1:0] avail;
  logic [CNT_W-1:0] trig_lvl;
  logic [IRQ_W-1:0] ev;
  logic [31:0] rd_data;
  logic [31:0] lc_val;
  logic [31:0] ctrl_val;

  // ---------------------------------------------------------------
  // character assembly
  // ---------------------------------------------------------------
  rx_frame_sampler u_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .rxd(rxd),
    .divisor(s_reg.divisor),
    .parity_en(s_reg.par_en),
    .parity_even(s_reg.par_even),
    .char_valid(char_valid),
    .char_out(rx_char)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    head_ch = s_reg.mem[s_reg.head];

    // read views
    lc_val = 32'h0000_0000;
    lc_val[LC_FE] = s_reg.fe;
    lc_val[LC_PE] = s_reg.pe;
    lc_val[LC_OE] = s_reg.oe;
    lc_val[LC_RA] = (s_reg.count != 5'h00);
    ctrl_val = 32'h0000_0000;
    ctrl_val[CT_FIFO] = s_reg.fifo_en;
    ctrl_val[CT_PEN] = s_reg.par_en;
    ctrl_val[CT_PEVEN] = s_reg.par_even;
    ctrl_val[CT_TRIG +: 2] = s_reg.trig_sel;
    ctrl_val[CT_DIV +: 16] = s_reg.divisor;

    case (s_reg.trig_sel)
      2'h0: trig_lvl = TRIG_L0;
      2'h1: trig_lvl = TRIG_L1;
      2'h2: trig_lvl = TRIG_L2;
      default: trig_lvl = TRIG_L3;
    endcase

    // apb decode; the answer comes one cycle after setup, no wait
    setup = apb_req.psel && !apb_req.penable;
    done = apb_req.psel && apb_req.penable && s_reg.rsp.pready;
    wr = done && apb_req.pwrite;
    rd = done && !apb_req.pwrite;
    hit = 1'b1;
    case (apb_req.paddr)
      ADDR_DATA: rd_data = {24'h00_0000, head_ch.data};
      ADDR_LINE: rd_data = lc_val;
      ADDR_CTRL: rd_data = ctrl_val;
      ADDR_SPARE: rd_data = {24'h00_0000, s_reg.spare};
      ADDR_ISTAT: rd_data = {27'h0, s_reg.istat};
      ADDR_IMASK: rd_data = {27'h0, s_reg.imask};
      default: begin
        rd_data = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    s_next.rsp.pready = setup;
    if (setup) begin
      s_next.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_data;
      s_next.rsp.pslverr = !hit;
    end

    // ---- status clear on read ----
    // the clear uses the value the read returned, so a fault that
    // arrives between setup and completion survives the read
    if (rd && apb_req.paddr == ADDR_LINE) begin
      if (s_reg.rsp.prdata[LC_FE]) s_next.fe = 1'b0;
      if (s_reg.rsp.prdata[LC_PE]) s_next.pe = 1'b0;
      if (s_reg.rsp.prdata[LC_OE]) s_next.oe = 1'b0;
    end

    // ---- reveal errors of the head character ----
    if (s_reg.count != 5'h00 && !s_reg.shown) begin
      s_next.shown = 1'b1;
      if (head_ch.fe) s_next.fe = 1'b1;
      if (head_ch.pe) s_next.pe = 1'b1;
    end

    // ---- fifo / holding register ----
    pop = rd && apb_req.paddr == ADDR_DATA && s_reg.count != 5'h00;
    avail = pop ? s_reg.count - 5'h01 : s_reg.count;
    // non-fifo mode is the same store with room for one
    full = s_reg.fifo_en ? (avail == FIFO_FULL) : (avail != 5'h00);
    push = char_valid && !full;
    ovr = char_valid && full;
    if (pop) begin
      s_next.head = s_reg.head + 4'h1;
      s_next.shown = 1'b0;
    end
    if (push) begin
      s_next.mem[s_reg.tail] = rx_char;
      s_next.tail = s_reg.tail + 4'h1;
    end else if (ovr && !s_reg.fifo_en) begin
      s_next.mem[s_reg.head] = rx_char;
      s_next.shown = 1'b0;
    end
    // in fifo mode an overrun leaves the store untouched
    if (ovr) s_next.oe = 1'b1;
    s_next.count = avail + {4'h0, push};

    // ---- register writes ----
    if (wr) begin
      case (apb_req.paddr)
        ADDR_CTRL: begin
          s_next.fifo_en = apb_req.pwdata[CT_FIFO];
          s_next.par_en = apb_req.pwdata[CT_PEN];
          s_next.par_even = apb_req.pwdata[CT_PEVEN];
          s_next.trig_sel = apb_req.pwdata[CT_TRIG +: 2];
          s_next.divisor = apb_req.pwdata[CT_DIV +: 16];
          // flush wins over a character stored in the same cycle
          if (apb_req.pwdata[CT_FLUSH]) begin
            s_next.head = 4'h0;
            s_next.tail = 4'h0;
            s_next.count = 5'h00;
            s_next.shown = 1'b0;
          end
        end
        ADDR_SPARE: s_next.spare = apb_req.pwdata[7:0];
        ADDR_ISTAT: begin
          s_next.istat = s_reg.istat & ~apb_req.pwdata[IRQ_W-1:0];
        end
        ADDR_IMASK: s_next.imask = apb_req.pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // ---- interrupt events; a set beats a same-cycle clear ----
    ev = '0;
    ev[IS_RA] = push;
    ev[IS_OE] = ovr;
    ev[IS_PE] = char_valid && rx_char.pe;
    ev[IS_FE] = char_valid && rx_char.fe;
    ev[IS_TRIG] = push && (avail + 5'h01 == trig_lvl);
    s_next.istat = s_next.istat | ev;
    s_next.irq = |(s_next.istat & s_next.imask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.divisor <= DIV_RESET;
      s_reg.spare <= SPARE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp = s_reg.rsp;
  assign irq = s_reg.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_fe_revealed: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.count != 5'h00 && !s_reg.shown && head_ch.fe |=> s_reg.fe)
    else $error("stop-bit fault of head character not shown");

  a_fe_read_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd && apb_req.paddr == ADDR_LINE && s_reg.rsp.prdata[LC_FE] &&
      (s_reg.shown || s_reg.count == 5'h00) |=> !s_reg.fe)
    else $error("stop-bit fault survived a status read");

  a_pe_revealed: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.count != 5'h00 && !s_reg.shown && head_ch.pe
      |=> s_reg.pe [*1] ##0 s_reg.shown)
    else $error("parity fault of head character not shown");

  a_single_overrun: assert property (
    @(posedge pclk) disable iff (!presetn)
    char_valid && !s_reg.fifo_en && s_reg.count == 5'h01 && !pop
      |=> s_reg.oe && s_reg.count == 5'h01)
    else $error("holding overwrite did not flag overrun");

  a_oe_read_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd && apb_req.paddr == ADDR_LINE && s_reg.rsp.prdata[LC_OE] &&
      !char_valid |=> !s_reg.oe)
    else $error("overrun survived a status read");

  a_no_early_oe: assert property (
    @(posedge pclk) disable iff (!presetn)
    char_valid && s_reg.fifo_en && s_reg.count < FIFO_FULL && !pop
      && !wr |=> s_reg.count == $past(s_reg.count) + 5'h01)
    else $error("character lost before the fifo was full");

  a_full_discard: assert property (
    @(posedge pclk) disable iff (!presetn)
    char_valid && s_reg.fifo_en && s_reg.count == FIFO_FULL && !pop
      && !wr |=> s_reg.oe && $stable(s_reg.tail) && $stable(s_reg.mem))
    else $error("fifo overrun not discarded or not flagged");

  a_ready_view: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && apb_req.paddr == ADDR_LINE && !apb_req.pwrite
      |=> s_reg.rsp.prdata[LC_RA] == ($past(s_reg.count) != 5'h00))
    else $error("receive available does not match the store");

  a_last_read_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    pop && s_reg.count == 5'h01 && !char_valid |=> s_reg.count == 5'h00)
    else $error("store not empty after the last character was read");

  a_spare_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && apb_req.paddr == ADDR_SPARE && !apb_req.pwrite
      |=> s_reg.rsp.prdata[31:8] == 24'h00_0000 &&
          s_reg.rsp.prdata[7:0] == s_reg.spare)
    else $error("spare byte read value wrong");

  a_spare_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && apb_req.paddr == ADDR_SPARE
      |=> s_reg.spare == $past(apb_req.pwdata[7:0]))
    else $error("spare byte write lost");
endmodule : uart_rx_line_status

// [inc/rx_status_pkg.sv]
// package: offsets, fields, reset values and carriers of the rx status block
package rx_status_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_LINE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_SPARE = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LC_RA = 0;
  localparam int LC_OE = 1;
  localparam int LC_PE = 2;
  localparam int LC_FE = 3;
  localparam int CT_FIFO = 0;
  localparam int CT_PEN = 1;
  localparam int CT_PEVEN = 2;
  localparam int CT_FLUSH = 3;
  localparam int CT_TRIG = 4;
  localparam int CT_DIV = 16;
  localparam int IS_RA = 0;
  localparam int IS_OE = 1;
  localparam int IS_PE = 2;
  localparam int IS_FE = 3;
  localparam int IS_TRIG = 4;
  localparam int IRQ_W = 5;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [1:0] RESYNC_SAMPLES = 2'h2;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic fe;
    logic pe;
    logic [7:0] data;
  } rx_char_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP = 3'b100
  } rx_state_t;
endpackage : rx_status_pkg

// [rtl/rx_frame_sampler.sv]
// serial frame sampler: 16x oversampled character assembly
`timescale 1ns/1ps
module rx_frame_sampler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line and settings
  input wire logic rxd,
  input wire logic [15:0] divisor,
  input wire logic parity_en,
  input wire logic parity_even,
  // assembled character
  output logic char_valid,
  output rx_status_pkg::rx_char_t char_out
);
  import rx_status_pkg::*;

  typedef struct packed {
    rx_state_t st;
    logic [15:0] div_cnt;
    logic [3:0] ovs;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic par_bad;
    logic [1:0] high_cnt;
    logic armed;
    logic valid;
    rx_char_t ch;
  } samp_t;

  samp_t s_reg, s_next;
  logic tick;
  logic [15:0] div_last;
  logic [1:0] high_inc;

  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    // a divisor of zero behaves as one
    div_last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
    tick = (s_reg.div_cnt >= div_last);
    s_next.div_cnt = tick ? 16'h0000 : s_reg.div_cnt + 16'h0001;
    high_inc = (s_reg.high_cnt == RESYNC_SAMPLES) ? s_reg.high_cnt
                                                  : s_reg.high_cnt + 2'h1;
    if (tick) begin
      s_next.ovs = s_reg.ovs + 4'h1;
      case (s_reg.st)
        RX_IDLE: begin
          s_next.ovs = 4'h0;
          if (rxd) begin
            s_next.high_cnt = high_inc;
            if (high_inc == RESYNC_SAMPLES) s_next.armed = 1'b1;
          end else begin
            s_next.high_cnt = 2'h0;
            if (s_reg.armed) s_next.st = RX_START;
          end
        end
        RX_START: if (s_reg.ovs == OVS_HALF) begin
          s_next.ovs = 4'h0;
          s_next.bit_idx = 3'h0;
          s_next.par_bad = 1'b0;
          // a glitch shorter than half a bit is not a start
          s_next.st = rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (s_reg.ovs == OVS_LAST) begin
          s_next.shift = {rxd, s_reg.shift[7:1]};
          s_next.bit_idx = s_reg.bit_idx + 3'h1;
          if (s_reg.bit_idx == 3'h7) begin
            s_next.st = parity_en ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: if (s_reg.ovs == OVS_LAST) begin
          s_next.par_bad = (^s_reg.shift) ^ rxd ^ ~parity_even;
          s_next.st = RX_STOP;
        end
        RX_STOP: if (s_reg.ovs == OVS_LAST) begin
          s_next.valid = 1'b1;
          s_next.ch.data = s_reg.shift;
          s_next.ch.pe = s_reg.par_bad;
          s_next.ch.fe = ~rxd;
          // a break ends here as one zero character; disarming keeps
          // a line held low from delivering any more of them
          s_next.armed = rxd;
          s_next.high_cnt = 2'h0;
          s_next.st = RX_IDLE;
        end
        default: s_next.st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign char_valid = s_reg.valid;
  assign char_out = s_reg.ch;

  a_break_disarms: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.valid && s_reg.ch.fe && !rxd |=>
      s_reg.st == RX_IDLE && !s_reg.armed)
    else $error("sampler not idle and disarmed after a break");
  a_low_line_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.st == RX_IDLE && !s_reg.armed |=> s_reg.st == RX_IDLE)
    else $error("character started while disarmed");
endmodule : rx_frame_sampler

// [verif/serial_tx_model.sv]
// serial transmitter model that drives the receive line
`timescale 1ns/1ps
module serial_tx_model (
  // clock
  input wire logic pclk,
  // frame request
  input wire logic send,
  input wire logic [7:0] data,
  input wire logic par_en,
  input wire logic par_even,
  input wire logic par_bad,
  input wire logic stop_bad,
  input wire logic brk,
  // line and status
  output logic rxd,
  output logic busy
);
  // ------------------------------------------------------------
  // frame generator, 16 pclk per bit at divisor 1
  // ------------------------------------------------------------
  task automatic put_bit(input logic b);
    rxd <= b;
    repeat (16) @(posedge pclk);
  endtask : put_bit

  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (send === 1'b1) begin
        busy <= 1'b1;
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(data[i]);
        if (par_en) put_bit(^data ^ !par_even ^ par_bad);
        put_bit(!stop_bad);
        // a break holds the line low far past one frame
        if (brk) repeat (300) @(posedge pclk);
        // idle gap so the receiver can re-arm after a fault
        rxd <= 1'b1;
        repeat (4) @(posedge pclk);
        busy <= 1'b0;
      end
    end
  end
endmodule : serial_tx_model

// [verif/uart_rx_line_status_bench.sv]
// self-checking bench of the rx line status block
`timescale 1ns/1ps
module uart_rx_line_status_bench;
  import rx_status_pkg::*;
  logic pclk, presetn, rxd, irq, busy, er;
  logic send, pen, pev, par_bad, stop_bad, brk;
  logic [7:0] data, b, c;
  logic [7:0] fq [17];
  logic [31:0] seed, rv;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  int err_count, n_checks;

  uart_rx_line_status u_uart_rx_line_status (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rxd(rxd), .irq(irq));
  serial_tx_model u_serial_tx_model (.pclk(pclk), .send(send),
    .data(data), .par_en(pen), .par_even(pev), .par_bad(par_bad),
    .stop_bad(stop_bad), .brk(brk), .rxd(rxd), .busy(busy));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one apb transfer; waits on pready, never on a cycle count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= wd;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (apb_rsp.pready !== 1'b1) begin
      err_count++;
      complete_run();
    end
    rv = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask : rdc

  task automatic rdd(input logic [7:0] e);
    apb(1'b0, ADDR_DATA, 32'h0);
    chk("data", {24'h0, rv[7:0]}, {24'h0, e});
  endtask : rdd

  task automatic tx(input logic [7:0] d, input logic pb, input logic sb,
                    input logic bk);
    int n;
    data <= d;
    par_bad <= pb;
    stop_bad <= sb;
    brk <= bk;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 1000);
    if (busy !== 1'b0) begin
      err_count++;
      complete_run();
    end
  endtask : tx

  // ------------------------------------------------------------
  // clock and sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    apb_req = '0;
    {send, pen, pev, par_bad, stop_bad, brk} = 6'h00;
    data = 8'h00;
    seed = 32'h0000F9F5;
    err_count = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ADDR_LINE, 32'h0, "line");
    rdc(ADDR_SPARE, 32'h0, "spare");
    rdc(ADDR_CTRL, 32'h00010000, "ctrl");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped", rv, 32'h0);
    for (int i = 0; i < 4; i++) begin
      b = 8'(xs());
      wr(ADDR_SPARE, {24'h0, b});
      rdc(ADDR_SPARE, {24'h0, b}, "spare");
    end
    rdc(ADDR_LINE, 32'h0, "line");
    // single character, interrupt raise, mask and clear
    b = 8'(xs());
    tx(b, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_LINE, 32'h1, "line");
    wr(ADDR_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ADDR_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(ADDR_IMASK, 32'h1);
    wr(ADDR_ISTAT, 32'h1F);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdd(b);
    rdc(ADDR_LINE, 32'h0, "line");
    // overwrite of an unread character
    b = 8'(xs());
    c = 8'(xs());
    tx(b, 1'b0, 1'b0, 1'b0);
    tx(c, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_LINE, 32'h3, "line");
    rdc(ADDR_LINE, 32'h1, "line");
    rdd(c);
    // odd then even parity, good and bad parity bit
    for (int m = 0; m < 2; m++) begin
      pen <= 1'b1;
      pev <= m[0];
      wr(ADDR_CTRL, 32'h00010002 | (32'(m) << 2));
      b = 8'(xs());
      tx(b, 1'b0, 1'b0, 1'b0);
      rdc(ADDR_LINE, 32'h1, "line");
      rdd(b);
      tx(b, 1'b1, 1'b0, 1'b0);
      rdc(ADDR_LINE, 32'h5, "line");
      rdc(ADDR_LINE, 32'h1, "line");
      rdd(b);
    end
    pen <= 1'b0;
    wr(ADDR_CTRL, 32'h00010000);
    // held break: one zero character, then resync
    tx(8'h00, 1'b0, 1'b1, 1'b1);
    rdc(ADDR_LINE, 32'h9, "line");
    rdc(ADDR_LINE, 32'h1, "line");
    rdd(8'h00);
    rdc(ADDR_LINE, 32'h0, "line");
    b = 8'(xs());
    tx(b, 1'b0, 1'b0, 1'b0);
    rdd(b);
    // fifo: fill to full, one more overruns, drain
    // trigger level 4, so the level event must wait for the fourth
    wr(ADDR_CTRL, 32'h00010011);
    wr(ADDR_ISTAT, 32'h1F);
    for (int i = 0; i < 17; i++) begin
      fq[i] = 8'(xs());
      tx(fq[i], 1'b0, i == 3, 1'b0);
      if (i == 2) rdc(ADDR_ISTAT, 32'h01, "istat");
      if (i == 3) rdc(ADDR_ISTAT, 32'h19, "istat");
      if (i == 15) rdc(ADDR_LINE, 32'h1, "line");
    end
    rdc(ADDR_LINE, 32'h3, "line");
    apb(1'b0, ADDR_ISTAT, 32'h0);
    chk("istat", rv, 32'h1B);
    for (int i = 0; i < 16; i++) begin
      if (i == 3) rdc(ADDR_LINE, 32'h9, "line");
      rdd(fq[i]);
    end
    rdc(ADDR_LINE, 32'h0, "line");
    // flush empties a loaded store and reads back as zero
    b = 8'(xs());
    tx(b, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_LINE, 32'h1, "line");
    wr(ADDR_CTRL, 32'h00010009);
    rdc(ADDR_LINE, 32'h0, "line");
    rdc(ADDR_CTRL, 32'h00010001, "ctrl");
    complete_run();
  end
endmodule : uart_rx_line_status_bench
